// >>> hw/smcr_regs.sv
/*
  serial register port and write-only control bank for a spindle and
  voice-coil controller: frame receiver, read-back driver, double-buffered
  coil setpoint, spindle control and delay fields, commutation sequencer.
  assumes the host drives select, serial clock and data asynchronously to
  ref_clk, with serial clock phases of at least 15 ns (ref_clk is 4 ns).
*/
`include "smcr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module smcr_regs #(
  parameter int FRAME_BITS = `SMCR_FRAME_BITS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_select,
  input wire logic serial_clk,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic [13:0] coil_setpoint,
  output logic coil_current_sign,
  output logic [12:0] coil_current_mag,
  output logic coil_drive_method,
  output logic coil_calibrate,
  output smcr_pkg::smcr_phase_t sequencer_phase,
  output logic internal_startup,
  output logic spinup_start,
  output logic spindle_logic_reset,
  output logic spindle_enable,
  output logic speed_period_select,
  output logic spindle_pwm_mode,
  output logic feedback_source_select,
  output logic mask_window_short,
  output logic [1:0] min_on_time_sel,
  output logic [11:0] min_on_cycles,
  output logic pole8_select,
  output logic [3:0] commutation_delay_field
);
  import smcr_pkg::*;

  // the receiver decodes fixed bit positions, so only the documented frame fits
  generate
    if (FRAME_BITS != `SMCR_FRAME_BITS)
    begin : g_bad_frame
      $error("smcr_regs: only a sixteen-bit frame is supported");
    end
    if (2 * `SMCR_DATA_LSB != `SMCR_FRAME_BITS)
    begin : g_bad_layout
      $error("smcr_regs: data byte must fill the second half of the frame");
    end
    // the longest on-time must fit the twelve-bit cycle count
    if (`SMCR_NS_TO_CYC(`SMCR_MIN_ON_10_NS) > 4095)
    begin : g_bad_min_on
      $error("smcr_regs: minimum on-time exceeds the cycle counter");
    end
  endgenerate

  localparam logic [11:0] MIN_ON_00 = 12'(`SMCR_NS_TO_CYC(`SMCR_MIN_ON_00_NS));
  localparam logic [11:0] MIN_ON_01 = 12'(`SMCR_NS_TO_CYC(`SMCR_MIN_ON_01_NS));
  localparam logic [11:0] MIN_ON_10 = 12'(`SMCR_NS_TO_CYC(`SMCR_MIN_ON_10_NS));
  localparam logic [11:0] MIN_ON_11 = 12'(`SMCR_NS_TO_CYC(`SMCR_MIN_ON_11_NS));
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
  localparam logic [4:0] ADDR_DONE = 5'(`SMCR_DATA_LSB - 1);
  localparam logic [4:0] DATA_FIRST = 5'(`SMCR_DATA_LSB);

  function automatic smcr_phase_t step_phase(input smcr_phase_t ph);
    case (ph)
      SMCR_PH1: step_phase = SMCR_PH2;
      SMCR_PH2: step_phase = SMCR_PH3;
      SMCR_PH3: step_phase = SMCR_PH4;
      SMCR_PH4: step_phase = SMCR_PH5;
      SMCR_PH5: step_phase = SMCR_PH6;
      default: step_phase = SMCR_PH1;
    endcase
  endfunction

  function automatic logic [11:0] min_on_lookup(input logic [1:0] sel);
    case (sel)
      2'h0: min_on_lookup = MIN_ON_00;
      2'h1: min_on_lookup = MIN_ON_01;
      2'h2: min_on_lookup = MIN_ON_10;
      default: min_on_lookup = MIN_ON_11;
    endcase
  endfunction

  // one-hot register select, shared by the write strobes and the read mux
  function automatic logic [3:0] reg_decode(input logic [6:0] addr);
    case (addr)
      `SMCR_ADDR_COIL_HIGH: reg_decode = 4'h1;
      `SMCR_ADDR_COIL_LOW: reg_decode = 4'h2;
      `SMCR_ADDR_SPIN_CTRL: reg_decode = 4'h4;
      `SMCR_ADDR_SPIN_DELAY: reg_decode = 4'h8;
      default: reg_decode = 4'h0;
    endcase
  endfunction

  // pin synchronisers; the third clock stage only serves edge detection
  // each serial clock phase must span at least three ref_clk cycles or an edge is lost
  logic sel_s1, sel_s2;
  logic sck_s1, sck_s2, sck_s3;
  logic sdi_s1, sdi_s2;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      sel_s1 <= serial_select;
      sel_s2 <= sel_s1;
      sck_s1 <= serial_clk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= serial_data_line_in;
      sdi_s2 <= sdi_s1;
    end
  end

  logic sck_rise;
  logic sck_fall;
  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;

  // frame receiver
  logic [4:0] bit_cnt;
  logic [15:0] shreg;
  logic [15:0] next_word;
  logic take_bit;
  logic frame_done;
  logic wr_commit;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  assign take_bit = sel_s2 & sck_rise & (bit_cnt <= LAST_BIT);
  assign next_word = {sdi_s2, shreg[15:1]};
  assign frame_done = take_bit & (bit_cnt == LAST_BIT);
  assign wr_commit = frame_done & (next_word[`SMCR_RW_POS] == 1'b0);
  assign wr_addr = next_word[`SMCR_DATA_LSB-1:`SMCR_ADDR_LSB];
  assign wr_data = next_word[15:`SMCR_DATA_LSB];

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_cnt <= 5'h00;
      shreg <= 16'h0000;
    end
    else if (!sel_s2)
      bit_cnt <= 5'h00;
    else if (take_bit)
    begin
      bit_cnt <= bit_cnt + 5'h01;
      shreg <= next_word;
    end
  end

  // register bank
  logic [7:0] coil_high_pending;
  logic [7:0] coil_high_active;
  logic [7:0] coil_low;
  logic [7:0] spin_ctrl;
  logic [7:0] spin_delay;
  logic ctrl_wr;
  logic delay_wr;
  logic step_edge;

  logic [3:0] wr_sel;
  logic seq_clear;

  // unmapped addresses decode to no strobe, so such writes are dropped
  assign wr_sel = reg_decode(wr_addr);
  assign ctrl_wr = wr_commit & wr_sel[2];
  assign delay_wr = wr_commit & wr_sel[3];
  assign step_edge = ctrl_wr & wr_data[`SMCR_SEQ_STEP_POS] & ~spin_ctrl[`SMCR_SEQ_STEP_POS];

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coil_high_pending <= `SMCR_RESET_REG;
      coil_high_active <= `SMCR_RESET_REG;
      coil_low <= `SMCR_RESET_REG;
    end
    else if (wr_commit)
    begin
      if (wr_sel[0])
        coil_high_pending <= wr_data;
      if (wr_sel[1])
      begin
        coil_low <= wr_data;
        coil_high_active <= coil_high_pending;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      spin_ctrl <= `SMCR_RESET_REG;
    else if (ctrl_wr)
      spin_ctrl <= wr_data;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      spin_delay <= `SMCR_RESET_REG;
      min_on_cycles <= `SMCR_RESET_MIN_ON;
    end
    else if (delay_wr)
    begin
      spin_delay <= wr_data;
      min_on_cycles <= min_on_lookup({wr_data[`SMCR_MIN_HI_POS], wr_data[`SMCR_MIN_LO_POS]});
    end
  end

  // the clear bit is a level, so it beats any step in the same write;
  // the stored bit still counts on the edge that writes it away
  assign seq_clear = spin_ctrl[`SMCR_SEQ_CLEAR_POS] | (ctrl_wr & wr_data[`SMCR_SEQ_CLEAR_POS]);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sequencer_phase <= SMCR_PH1;
    else if (seq_clear)
      sequencer_phase <= SMCR_PH1;
    else if (step_edge)
      sequencer_phase <= step_phase(sequencer_phase);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      spinup_start <= 1'b0;
    else
      spinup_start <= ctrl_wr & wr_data[`SMCR_RUN_POS] & ~spin_ctrl[`SMCR_RUN_POS];
  end

  // read-back driver; write-only registers echo their stored value
  function automatic logic [7:0] read_back(input logic [6:0] addr, input logic [7:0] hi,
    input logic [7:0] lo, input logic [7:0] ctl, input logic [7:0] dly);
    case (reg_decode(addr))
      4'h1: read_back = hi;
      4'h2: read_back = lo;
      4'h4: read_back = ctl;
      4'h8: read_back = dly;
      default: read_back = 8'h00;
    endcase
  endfunction

  logic rd_req;
  logic [6:0] rd_addr;
  logic [7:0] tx;
  logic [7:0] rd_word;

  // the word is sampled once, at the fall after the address; a write landing
  // later cannot reach bits already on the line
  assign rd_word = read_back(rd_addr, coil_high_pending, coil_low, spin_ctrl, spin_delay);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_req <= 1'b0;
      rd_addr <= 7'h00;
    end
    else if (!sel_s2)
      rd_req <= 1'b0;
    else if (take_bit && bit_cnt == ADDR_DONE)
    begin
      rd_req <= next_word[`SMCR_DATA_LSB];
      rd_addr <= next_word[15:`SMCR_DATA_LSB+1];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx <= 8'h00;
      serial_data_line_out <= 1'b0;
      serial_data_line_oe <= 1'b0;
    end
    else if (!sel_s2)
      serial_data_line_oe <= 1'b0;
    else if (rd_req && sck_fall && bit_cnt == DATA_FIRST && !serial_data_line_oe)
    begin
      tx <= rd_word;
      serial_data_line_out <= rd_word[0];
      serial_data_line_oe <= 1'b1;
    end
    else if (serial_data_line_oe && take_bit && bit_cnt < LAST_BIT)
    begin
      tx <= {1'b0, tx[7:1]};
      serial_data_line_out <= tx[1];
    end
  end

  // outputs, slices of the registers; spindle_logic_reset is the inverted run bit
  assign coil_setpoint = {coil_high_active[`SMCR_COIL_HIGH_MSB:0], coil_low};
  assign coil_current_sign = coil_high_active[`SMCR_COIL_HIGH_MSB];
  assign coil_current_mag = {coil_high_active[`SMCR_COIL_HIGH_MSB-1:0], coil_low};
  assign coil_drive_method = coil_high_active[`SMCR_COIL_METHOD_POS];
  assign coil_calibrate = coil_high_active[`SMCR_COIL_CAL_POS];
  assign internal_startup = spin_ctrl[`SMCR_STARTUP_POS];
  assign spindle_logic_reset = ~spin_ctrl[`SMCR_RUN_POS];
  assign spindle_enable = spin_ctrl[`SMCR_SPIN_EN_POS];
  assign speed_period_select = spin_ctrl[`SMCR_PERIOD_POS];
  assign spindle_pwm_mode = spin_ctrl[`SMCR_SPIN_PWM_POS];
  assign feedback_source_select = spin_ctrl[`SMCR_FEEDBACK_POS];
  assign mask_window_short = spin_delay[`SMCR_MASK_POS];
  assign min_on_time_sel = {spin_delay[`SMCR_MIN_HI_POS], spin_delay[`SMCR_MIN_LO_POS]};
  assign pole8_select = spin_delay[`SMCR_POLE8_POS];

  // delay field stored msb at bit 4; one step is 1.875 degrees, 0 means 1.875
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_delay
      assign commutation_delay_field[gi] = spin_delay[`SMCR_DELAY_LSB_POS - gi];
    end
  endgenerate
endmodule

`default_nettype wire

// >>> hw/smcr_defines.svh
/*
  constants of the serial motor-control register bank: register addresses,
  field positions, reset values and timing figures.
  assumes it is included by bare name from every file that needs it.
*/
`ifndef SMCR_DEFINES_SVH
`define SMCR_DEFINES_SVH

// frame layout
`define SMCR_FRAME_BITS 16
`define SMCR_RW_POS 0
`define SMCR_ADDR_LSB 1
`define SMCR_DATA_LSB 8

// 7-bit register addresses
`define SMCR_ADDR_COIL_HIGH 7'h0E
`define SMCR_ADDR_COIL_LOW 7'h1E
`define SMCR_ADDR_SPIN_CTRL 7'h2E
`define SMCR_ADDR_SPIN_DELAY 7'h3E

// reset values
`define SMCR_RESET_REG 8'h00
`define SMCR_RESET_MIN_ON 12'h000

// coil setpoint high register fields, and the sign bit position within the 14-bit setpoint
`define SMCR_COIL_HIGH_MSB 5
`define SMCR_COIL_METHOD_POS 6
`define SMCR_COIL_CAL_POS 7
`define SMCR_COIL_SIGN_POS 13

// spindle control fields
`define SMCR_SEQ_STEP_POS 0
`define SMCR_STARTUP_POS 1
`define SMCR_SEQ_CLEAR_POS 2
`define SMCR_RUN_POS 3
`define SMCR_SPIN_EN_POS 4
`define SMCR_PERIOD_POS 5
`define SMCR_SPIN_PWM_POS 6
`define SMCR_FEEDBACK_POS 7

// spindle delay fields
`define SMCR_MASK_POS 0
`define SMCR_MIN_LO_POS 1
`define SMCR_MIN_HI_POS 2
`define SMCR_POLE8_POS 3
`define SMCR_DELAY_MSB_POS 4
`define SMCR_DELAY_LSB_POS 7

// clock and minimum on-times
`define SMCR_CLK_MHZ 250
`define SMCR_MIN_ON_00_NS 5900
`define SMCR_MIN_ON_01_NS 1400
`define SMCR_MIN_ON_10_NS 12000
`define SMCR_MIN_ON_11_NS 5210
`define SMCR_NS_TO_CYC(ns) ((((ns) * `SMCR_CLK_MHZ) + 999) / 1000)

`endif

// >>> hw/smcr_pkg.sv
/*
  types shared by the serial motor-control register bank.
  assumes nothing beyond a SystemVerilog compiler.
*/
package smcr_pkg;
  // spindle commutation phases, gray coded along the step order
  typedef enum logic [2:0] {
    SMCR_PH1 = 3'h0,
    SMCR_PH2 = 3'h1,
    SMCR_PH3 = 3'h3,
    SMCR_PH4 = 3'h2,
    SMCR_PH5 = 3'h6,
    SMCR_PH6 = 3'h4
  } smcr_phase_t;
endpackage

// >>> tb/smcr_regs_props.sv
/*
  concurrent checks on the ports of the serial register bank.
  assumes it is bound onto smcr_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module smcr_regs_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_select,
  input wire logic serial_clk,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic [13:0] coil_setpoint,
  input wire logic coil_current_sign,
  input wire logic [12:0] coil_current_mag,
  input wire smcr_pkg::smcr_phase_t sequencer_phase,
  input wire logic spinup_start,
  input wire logic spindle_logic_reset,
  input wire logic [1:0] min_on_time_sel,
  input wire logic [11:0] min_on_cycles
);
  import smcr_pkg::*;
  // gray successor of each phase code; the unused codes fall back to phase 1
  localparam logic [2:0] NXT [8] = '{3'h1, 3'h3, 3'h6, 3'h2, 3'h0, 3'h0, 3'h4, 3'h0};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // long enough for the select synchroniser to have settled
  sequence idle_s;
    (!serial_select) [*8];
  endsequence
  sequence drive_start_s;
    $rose(serial_data_line_oe);
  endsequence
  coil_split_a: assert property (coil_setpoint == {coil_current_sign, coil_current_mag})
    else $error("setpoint differs from sign and magnitude");
  quiet_hold_a: assert property (idle_s |=> $stable(coil_setpoint) && $stable(min_on_cycles))
    else $error("register changed with no frame");
  oe_release_a: assert property (idle_s |-> !serial_data_line_oe)
    else $error("data line driven while deselected");
  oe_start_a: assert property (drive_start_s |-> serial_select && !serial_clk)
    else $error("read drive began outside clock low phase");
  out_shift_a: assert property (serial_data_line_oe && $past(serial_data_line_oe) && $changed(serial_data_line_out)
    |-> serial_clk)
    else $error("read bit changed while clock low");
  phase_step_a: assert property ($changed(sequencer_phase) |-> sequencer_phase == SMCR_PH1 ||
    sequencer_phase == NXT[$past(sequencer_phase)])
    else $error("sequencer skipped a phase");
  min_on_map_a: assert property ($changed(min_on_cycles) |-> min_on_cycles == (min_on_time_sel == 2'h0 ? 12'h5C3 :
    min_on_time_sel == 2'h1 ? 12'h15E : min_on_time_sel == 2'h2 ? 12'hBB8 : 12'h517))
    else $error("minimum on time does not match selection");
  spinup_run_a: assert property ($fell(spindle_logic_reset) |-> ##[0:2] spinup_start)
    else $error("run set without spin-up start");
  spinup_pulse_a: assert property (spinup_start |=> !spinup_start && !spindle_logic_reset)
    else $error("spin-up start not a single pulse");
endmodule
`default_nettype wire

// >>> tb/smcr_host.sv
/*
  host model driving select, serial clock and data of the register port.
  assumes the bench resolves the shared data line into serial_data_line.
*/
`timescale 1ns/1ps
`default_nettype none
module smcr_host (
  output logic serial_select,
  output logic serial_clk,
  output logic host_data,
  output logic host_data_en,
  input wire logic serial_data_line
);
  initial
  begin
    serial_select = 0;
    serial_clk = 0;
    host_data = 0;
    host_data_en = 0;
  end
  // n pulses of a 125 ns clock; the clock stands low outside frames
  task automatic frame(input logic [15:0] w, input int n, output logic [7:0] q);
    int i;
    q = 8'h00;
    host_data_en = 1;
    serial_select = 1;
    #40;
    for (i = 0; i < n; i++)
    begin
      host_data_en = !(w[0] && i >= 8);
      host_data = w[i % 16];
      #62.5;
      serial_clk = 1;
      if (i >= 8 && i < 16)
        q[i - 8] = serial_data_line;
      #62.5;
      serial_clk = 0;
    end
    #30;
    serial_select = 0;
    host_data_en = 0;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> tb/smcr_regs_tb_top.sv
/*
  self-checking bench: random frames against a behavioural register model.
  assumes smcr_regs, the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module smcr_regs_tb_top;
  import smcr_pkg::*;
  logic ref_clk = 0, rstn = 0, tog = 0, hdat, hen, serial_select, serial_clk;
  logic serial_data_line_out, serial_data_line_oe, coil_current_sign, coil_drive_method, coil_calibrate;
  logic internal_startup, spinup_start, spindle_logic_reset, spindle_enable, speed_period_select;
  logic spindle_pwm_mode, feedback_source_select, mask_window_short, pole8_select;
  logic [13:0] coil_setpoint;
  logic [12:0] coil_current_mag;
  logic [1:0] min_on_time_sel;
  logic [11:0] min_on_cycles, on;
  logic [3:0] commutation_delay_field;
  smcr_phase_t sequencer_phase;
  wire logic serial_data_line_in;
  logic [7:0] hi, lo, am, ctl, dly, q, d, exp;
  logic [6:0] a;
  int errors = 0, samples_checked = 0, ph, n, k;
  bit rw;
  smcr_phase_t PH [6] = '{SMCR_PH1, SMCR_PH2, SMCR_PH3, SMCR_PH4, SMCR_PH5, SMCR_PH6};
  logic [11:0] ON [4] = '{12'h5C3, 12'h15E, 12'hBB8, 12'h517};
  always #2 ref_clk = ~ref_clk;
  // a released line shows a changing pattern, never the last driven bit
  always @(posedge ref_clk) tog <= ~tog;
  assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out : (hen ? hdat : tog);
  smcr_regs smcr_regs_inst (.*);
  smcr_host smcr_host_inst (.serial_select(serial_select), .serial_clk(serial_clk), .host_data(hdat),
    .host_data_en(hen), .serial_data_line(serial_data_line_in));
  task automatic mreset();
    {hi, lo, am, ctl, dly, on} = '0;
    ph = 0;
  endtask
  task automatic check();
    `CHK("setpoint", {am[5:0], lo}, coil_setpoint)
    `CHK("method", am[6], coil_drive_method)
    `CHK("calibrate", am[7], coil_calibrate)
    `CHK("phase", PH[ph], sequencer_phase)
    `CHK("control", {ctl[7:3], ctl[1]}, {feedback_source_select, spindle_pwm_mode, speed_period_select,
      spindle_enable, ~spindle_logic_reset, internal_startup})
    `CHK("delay", {dly[4], dly[5], dly[6], dly[7], dly[3:0]}, {commutation_delay_field, pole8_select,
      min_on_time_sel, mask_window_short})
    `CHK("on_time", on, min_on_cycles)
  endtask
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #300000;
    errors++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'hF5F51E1E));
    mreset();
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1;
    repeat (4) @(posedge ref_clk);
    check();
    for (k = 0; k < 90; k++)
    begin
      a = ($urandom % 5 < 4) ? {3'($urandom % 4), 4'hE} : 7'($urandom);
      d = 8'($urandom);
      rw = ($urandom % 3 == 0);
      n = $urandom % 8;
      n = (n == 0) ? 1 + $urandom % 15 : (n == 1) ? 17 + $urandom % 4 : 16;
      exp = a == 7'h0E ? hi : a == 7'h1E ? lo : a == 7'h2E ? ctl : a == 7'h3E ? dly : 8'h00;
      @(posedge ref_clk) #1;
      smcr_host_inst.frame({d, a, rw}, n, q);
      if (n >= 16 && rw)
        `CHK("read", exp, q)
      if (n >= 16 && !rw)
        case (a)
          7'h0E: hi = d;
          7'h1E: {lo, am} = {d, hi};
          7'h2E: {ph, ctl} = {(d[2] || ctl[2]) ? 0 : (d[0] && !ctl[0]) ? (ph + 1) % 6 : ph, d};
          7'h3E: {dly, on} = {d, ON[d[2:1]]};
          default: ;
        endcase
      check();
      if (k == 60)
      begin
        @(posedge ref_clk) #1 rstn = 0;
        repeat (3) @(posedge ref_clk);
        #1 rstn = 1;
        mreset();
        repeat (4) @(posedge ref_clk);
        check();
      end
    end
    test_done();
  end
endmodule
bind smcr_regs smcr_regs_props smcr_regs_props_inst (.*);
`default_nettype wire
